//--- src/dasr_fifo.sv
// sample fifo with registered read data and registered ready
`timescale 1ns/1ns
`default_nettype none
module dasr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_BITS = $clog2(DEPTH + 1);
    localparam logic [CNT_BITS-1:0] FULL_CNT = CNT_BITS'(DEPTH);
    localparam logic [PTR_BITS-1:0] LAST_PTR = PTR_BITS'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_BITS-1:0] wr_ptr_ff;
    logic [PTR_BITS-1:0] rd_ptr_ff;
    logic [CNT_BITS-1:0] cnt_ff;
    logic [CNT_BITS-1:0] nxt_cnt;
    logic push;
    logic load;

    assign push = in_valid_in && in_ready_out;
    // output stage refills from storage when empty or being drained
    assign load = (cnt_ff != '0) && (!out_valid_out || out_ready_in);
    assign nxt_cnt = cnt_ff + CNT_BITS'(push) - CNT_BITS'(load);

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
            in_ready_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (load) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            end
            cnt_ff <= nxt_cnt;
            in_ready_out <= (nxt_cnt < FULL_CNT);
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end else if (load) begin
            out_valid_out <= 1'b1;
            out_data_out <= mem_ff[rd_ptr_ff];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- src/dasr_pkg.sv
// constants and types shared by the dual channel serial readout block
package dasr_pkg;

    // clock rate of sys_clk_in
    localparam int CLK_MHZ = 100;

    // result width choices and the default build
    localparam int RES_BITS_16 = 16;
    localparam int RES_BITS_14 = 14;
    localparam int RES_BITS_12 = 12;
    localparam int RES_BITS_DEF = RES_BITS_16;
    localparam int FIFO_DEPTH_DEF = 8;

    // falling serial clock edge figures of a frame
    localparam int CONV_EDGES = 14;
    localparam int MSB_EDGE = 15;
    localparam int EDGE_CNT_BITS = 6;
    localparam logic [EDGE_CNT_BITS-1:0] EDGE_CNT_MAX = 6'h3F;

    // 16-bit reference codes; narrower widths take the top bits
    localparam logic [15:0] negative_full_scale_code = 16'h8000;
    localparam logic [15:0] positive_full_scale_code = 16'h7FFF;
    localparam logic [15:0] below_midscale_code = 16'hFFFF;
    localparam logic [15:0] midscale_code = 16'h0000;

    // frame select high time after an abort, in ns
    localparam int abort_min_high_time_16_ns = 120;
    localparam int abort_min_high_time_14_ns = 100;
    localparam int abort_min_high_time_12_ns = 70;
    localparam int ABORT_CNT_BITS = 8;

    // synchroniser idle levels
    localparam logic FRAME_SEL_IDLE = 1'b1;
    localparam logic SERIAL_CLK_IDLE = 1'b0;

    // least time rounds up, never below one cycle
    function automatic int ns_to_min_cycles(input int ns);
        int cyc;
        cyc = (ns * CLK_MHZ + 999) / 1000;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    function automatic int abort_min_high_time_ns(input int res);
        if (res == RES_BITS_16) begin
            return abort_min_high_time_16_ns;
        end
        if (res == RES_BITS_14) begin
            return abort_min_high_time_14_ns;
        end
        return abort_min_high_time_12_ns;
    endfunction

    // one simultaneous sample pair, raw offset binary in the low bits
    typedef struct packed {
        logic [15:0] chan_a;
        logic [15:0] chan_b;
    } dasr_pair_type;

    typedef enum logic [1:0] {
        DASR_IDLE = 2'b00,
        DASR_CONVERT = 2'b01,
        DASR_SHIFT = 2'b11,
        DASR_TRAIL = 2'b10
    } dasr_state_type;

endpackage

//--- src/dasr_sync3.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module dasr_sync3 #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_ff;
    logic stage2_ff;
    logic stage3_ff;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= IDLE_LEVEL;
            stage2_ff <= IDLE_LEVEL;
            stage3_ff <= IDLE_LEVEL;
        end else begin
            meta_ff <= pin_in;
            stage2_ff <= meta_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= IDLE_LEVEL;
        end else if (stage2_ff == stage3_ff) begin
            level_out <= stage3_ff;
        end
    end
endmodule
`default_nettype wire

//--- src/dasr_top.sv
// dual channel simultaneous sample serial readout and conversion sequencer
//
// Function
// - one frame is one conversion plus readout, from select fall to select rise
// - select falling enables both data outputs and drives them low
// - for 14 serial clocks after frame start both outputs stay zero
// - 15th falling edge resumes sampling and puts out each channel's MSB
// - each following falling edge launches the next result bit, MSB first
// - LSB on edge 30, 28 or 26; zeros after it until frame end
// - every result on both channels is twos complement
// - full scale codes 8000/7FFF, midscale 0000, below midscale FFFF, truncated
// - result width 16, 14 or 12 is a build parameter
// - both channels sampled together; A on first output, B on second
// - select rising ends the frame and floats both outputs
// - host may raise select anywhere; device accepts it at any cycle
// - select rising before edge 15 abandons conversion and resumes sampling
// - select rising after edge 15 leaves bits already sent valid
`timescale 1ns/1ns
`default_nettype none
module dasr_top #(
    parameter int RES_BITS = dasr_pkg::RES_BITS_DEF,
    parameter int FIFO_DEPTH = dasr_pkg::FIFO_DEPTH_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic frame_sel_n_in,
    input wire logic serial_clk_in,
    input wire dasr_pkg::dasr_pair_type sample_in,
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    output logic channel_a_serial_out,
    output logic channel_a_serial_oe_n_out,
    output logic channel_b_serial_out,
    output logic channel_b_serial_oe_n_out,
    output logic sample_hold_out,
    output logic frame_active_out,
    output logic conversion_abort_out,
    output logic acquisition_short_out
);
    import dasr_pkg::*;

    localparam int LSB_EDGE = CONV_EDGES + RES_BITS;
    localparam logic [EDGE_CNT_BITS-1:0] MSB_EDGE_CNT = EDGE_CNT_BITS'(MSB_EDGE);
    localparam logic [EDGE_CNT_BITS-1:0] LSB_EDGE_CNT = EDGE_CNT_BITS'(LSB_EDGE);
    localparam int ABORT_MIN_CYC = ns_to_min_cycles(abort_min_high_time_ns(RES_BITS));
    localparam logic [ABORT_CNT_BITS-1:0] ABORT_MIN_CNT = ABORT_CNT_BITS'(ABORT_MIN_CYC);
    localparam logic [ABORT_CNT_BITS-1:0] ABORT_CNT_MAX = '1;
    localparam logic [RES_BITS-1:0] SIGN_FLIP = negative_full_scale_code[15 -: RES_BITS];
    localparam logic [RES_BITS-1:0] MID_CODE = midscale_code[15 -: RES_BITS];

    // raw offset binary to twos complement: 0 -> 8000, midscale -> 0000
    function automatic logic [RES_BITS-1:0] to_twos(input logic [15:0] raw);
        return raw[RES_BITS-1:0] ^ SIGN_FLIP;
    endfunction

    logic frame_sel_n_s;
    logic serial_clk_s;
    logic frame_sel_n_prev_ff;
    logic serial_clk_prev_ff;
    logic frame_start;
    logic frame_end;
    logic sclk_fall;
    dasr_state_type state_ff;
    dasr_state_type nxt_state;
    logic [EDGE_CNT_BITS-1:0] edge_cnt_ff;
    logic [EDGE_CNT_BITS-1:0] nxt_edge_cnt;
    logic [RES_BITS-1:0] shift_a_ff;
    logic [RES_BITS-1:0] shift_b_ff;
    logic [ABORT_CNT_BITS-1:0] high_cnt_ff;
    logic aborted_ff;
    dasr_pair_type fifo_data;
    logic fifo_valid;

    dasr_sync3 #(
        .IDLE_LEVEL(FRAME_SEL_IDLE)
    ) u_sync_frame_sel (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pin_in(frame_sel_n_in),
        .level_out(frame_sel_n_s)
    );

    dasr_sync3 #(
        .IDLE_LEVEL(SERIAL_CLK_IDLE)
    ) u_sync_serial_clk (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pin_in(serial_clk_in),
        .level_out(serial_clk_s)
    );

    // converted samples wait here; a full fifo stalls the analog source
    dasr_fifo #(
        .WIDTH($bits(dasr_pair_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_sample_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_data_in(sample_in),
        .in_valid_in(sample_valid_in),
        .in_ready_out(sample_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(frame_start)
    );

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_sel_n_prev_ff <= FRAME_SEL_IDLE;
            serial_clk_prev_ff <= SERIAL_CLK_IDLE;
        end else begin
            frame_sel_n_prev_ff <= frame_sel_n_s;
            serial_clk_prev_ff <= serial_clk_s;
        end
    end

    assign frame_start = frame_sel_n_prev_ff && !frame_sel_n_s;
    assign frame_end = !frame_sel_n_prev_ff && frame_sel_n_s;
    // serial clock edges only count while select is low
    assign sclk_fall = serial_clk_prev_ff && !serial_clk_s && !frame_sel_n_s;

    // saturating falling edge count within the frame
    always_comb begin
        nxt_edge_cnt = edge_cnt_ff;
        if (frame_start) begin
            nxt_edge_cnt = '0;
        end else if (sclk_fall && edge_cnt_ff != EDGE_CNT_MAX) begin
            nxt_edge_cnt = edge_cnt_ff + 1'b1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            DASR_IDLE: begin
                if (frame_start) begin
                    nxt_state = DASR_CONVERT;
                end
            end
            DASR_CONVERT: begin
                if (frame_end) begin
                    nxt_state = DASR_IDLE;
                end else if (nxt_edge_cnt == MSB_EDGE_CNT) begin
                    nxt_state = DASR_SHIFT;
                end
            end
            DASR_SHIFT: begin
                if (frame_end) begin
                    nxt_state = DASR_IDLE;
                end else if (sclk_fall && edge_cnt_ff == LSB_EDGE_CNT) begin
                    nxt_state = DASR_TRAIL;
                end
            end
            DASR_TRAIL: begin
                if (frame_end) begin
                    nxt_state = DASR_IDLE;
                end
            end
            default: begin
                nxt_state = DASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= DASR_IDLE;
            edge_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            edge_cnt_ff <= nxt_edge_cnt;
        end
    end

    // both channels come from one fifo word, so they share one sample instant
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_a_ff <= '0;
            shift_b_ff <= '0;
        end else if (frame_start) begin
            if (fifo_valid) begin
                shift_a_ff <= to_twos(fifo_data.chan_a);
                shift_b_ff <= to_twos(fifo_data.chan_b);
            end else begin
                // no sample waiting: report midscale rather than stale data
                shift_a_ff <= MID_CODE;
                shift_b_ff <= MID_CODE;
            end
        end else if (sclk_fall && state_ff == DASR_SHIFT && nxt_state == DASR_SHIFT) begin
            shift_a_ff <= {shift_a_ff[RES_BITS-2:0], 1'b0};
            shift_b_ff <= {shift_b_ff[RES_BITS-2:0], 1'b0};
        end
    end

    // serial data: zero while converting, result bits, then trailing zeros
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_a_serial_out <= 1'b0;
            channel_b_serial_out <= 1'b0;
        end else if (frame_start || frame_end) begin
            channel_a_serial_out <= 1'b0;
            channel_b_serial_out <= 1'b0;
        end else if (sclk_fall) begin
            if (nxt_state == DASR_SHIFT && nxt_edge_cnt == MSB_EDGE_CNT) begin
                channel_a_serial_out <= shift_a_ff[RES_BITS-1];
                channel_b_serial_out <= shift_b_ff[RES_BITS-1];
            end else if (nxt_state == DASR_SHIFT) begin
                channel_a_serial_out <= shift_a_ff[RES_BITS-2];
                channel_b_serial_out <= shift_b_ff[RES_BITS-2];
            end else begin
                channel_a_serial_out <= 1'b0;
                channel_b_serial_out <= 1'b0;
            end
        end
    end

    // drive enables are low while the pins are driven
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_a_serial_oe_n_out <= 1'b1;
            channel_b_serial_oe_n_out <= 1'b1;
            frame_active_out <= 1'b0;
        end else if (frame_end) begin
            channel_a_serial_oe_n_out <= 1'b1;
            channel_b_serial_oe_n_out <= 1'b1;
            frame_active_out <= 1'b0;
        end else if (frame_start) begin
            channel_a_serial_oe_n_out <= 1'b0;
            channel_b_serial_oe_n_out <= 1'b0;
            frame_active_out <= 1'b1;
        end
    end

    // hold from frame start until edge 15 or an early select rise
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_hold_out <= 1'b0;
            conversion_abort_out <= 1'b0;
        end else begin
            conversion_abort_out <= frame_end && state_ff == DASR_CONVERT;
            if (frame_start) begin
                sample_hold_out <= 1'b1;
            end else if (frame_end || nxt_state == DASR_SHIFT) begin
                sample_hold_out <= 1'b0;
            end
        end
    end

    // a frame ended before the full readout is an abort; check the high time
    // that follows it, since a short one starves the next acquisition
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aborted_ff <= 1'b0;
            high_cnt_ff <= '0;
            acquisition_short_out <= 1'b0;
        end else begin
            acquisition_short_out <= 1'b0;
            if (frame_end) begin
                aborted_ff <= (state_ff != DASR_TRAIL);
                high_cnt_ff <= '0;
            end else if (frame_start) begin
                acquisition_short_out <= aborted_ff && (high_cnt_ff < ABORT_MIN_CNT);
                aborted_ff <= 1'b0;
            end else if (frame_sel_n_s && high_cnt_ff != ABORT_CNT_MAX) begin
                high_cnt_ff <= high_cnt_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/dasr_host_model.sv
// host side model: frame select, serial clock, bit capture
`timescale 1ns/1ns
`default_nettype none
module dasr_host_model (
    input wire logic sys_clk_in,
    input wire logic line_a_in,
    input wire logic line_b_in,
    output logic frame_sel_n_out,
    output logic serial_clk_out
);
    initial begin
        frame_sel_n_out = 1'b1;
        serial_clk_out = 1'b0;
    end
    // 80 ns, half of the 160 ns serial clock
    task automatic half();
        repeat (8) @(negedge sys_clk_in);
    endtask
    task automatic do_frame(input int falls, input int high_cyc,
                            output logic [32:1] bits_a, output logic [32:1] bits_b);
        bits_a = '0;
        bits_b = '0;
        @(negedge sys_clk_in);
        frame_sel_n_out = 1'b0;
        half();
        serial_clk_out = 1'b1;
        for (int k = 1; k <= falls; k++) begin
            half();
            serial_clk_out = 1'b0;
            half();
            bits_a[k] = line_a_in;
            bits_b[k] = line_b_in;
            serial_clk_out = 1'b1;
        end
        half();
        frame_sel_n_out = 1'b1;
        // clock stays high through the wait, then returns low; a short wait breaks the high time on purpose
        repeat (high_cyc) @(negedge sys_clk_in);
        serial_clk_out = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/dasr_top_chk.sv
// concurrent checks on the serial readout block ports
`timescale 1ns/1ns
`default_nettype none
module dasr_chk (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic frame_sel_n_in,
    input wire logic channel_a_serial_out,
    input wire logic channel_a_serial_oe_n_out,
    input wire logic channel_b_serial_out,
    input wire logic channel_b_serial_oe_n_out,
    input wire logic sample_hold_out,
    input wire logic frame_active_out,
    input wire logic conversion_abort_out,
    input wire logic acquisition_short_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_open_low;
        frame_active_out && !channel_a_serial_oe_n_out && !channel_b_serial_oe_n_out;
    endsequence
    sequence s_zero_out;
        !channel_a_serial_out && !channel_b_serial_out;
    endsequence
    sequence s_floating;
        channel_a_serial_oe_n_out && channel_b_serial_oe_n_out;
    endsequence
    property p_open_drive; $rose(frame_active_out) |-> s_open_low ##0 s_zero_out; endproperty
    a_open_drive: assert property (p_open_drive) else $error("outputs not low at frame start");
    property p_sel_fall; $fell(frame_sel_n_in) |-> ##[3:8] frame_active_out; endproperty
    a_sel_fall: assert property (p_sel_fall) else $error("frame did not open");
    property p_sel_rise; $rose(frame_sel_n_in) |-> ##[3:8] !frame_active_out; endproperty
    a_sel_rise: assert property (p_sel_rise) else $error("frame did not close");
    property p_float; $fell(frame_active_out) |-> s_floating; endproperty
    a_float: assert property (p_float) else $error("outputs still driven after frame");
    property p_hold_zero; sample_hold_out |-> s_zero_out; endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("data moved while converting");
    property p_hold_end; $fell(frame_active_out) |-> !sample_hold_out; endproperty
    a_hold_end: assert property (p_hold_end) else $error("hold kept after frame end");
    property p_data_move; $changed(channel_a_serial_out) && frame_active_out |-> !sample_hold_out;
    endproperty
    a_data_move: assert property (p_data_move) else $error("result bit before sampling resumed");
    property p_idle_zero; !frame_active_out && !$past(frame_active_out) |-> s_zero_out ##0 s_floating;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("outputs active outside frame");
    property p_abort_pulse; conversion_abort_out |=> !conversion_abort_out; endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
    property p_short_start; acquisition_short_out |-> ##[0:2] frame_active_out; endproperty
    a_short_start: assert property (p_short_start) else $error("short flag away from start");
    property p_pair_oe; channel_a_serial_oe_n_out == channel_b_serial_oe_n_out; endproperty
    a_pair_oe: assert property (p_pair_oe) else $error("channel enables differ");
endmodule
bind dasr_top dasr_chk u_dasr_chk (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .frame_sel_n_in(frame_sel_n_in),
    .channel_a_serial_out(channel_a_serial_out),
    .channel_a_serial_oe_n_out(channel_a_serial_oe_n_out),
    .channel_b_serial_out(channel_b_serial_out),
    .channel_b_serial_oe_n_out(channel_b_serial_oe_n_out),
    .sample_hold_out(sample_hold_out),
    .frame_active_out(frame_active_out),
    .conversion_abort_out(conversion_abort_out),
    .acquisition_short_out(acquisition_short_out)
);
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the dual channel serial readout block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dasr_pkg::*;
    localparam int RES = RES_BITS_16;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    dasr_pair_type sample_in = '0;
    logic sample_valid_in = 1'b0;
    logic sample_ready_out, line_a, line_b, last_a, last_b, sel_n, sclk;
    logic out_a, oe_a, out_b, oe_b, hold, active, abort_p, short_p;
    int fail_count = 0;
    int checks = 0;
    int abort_seen = 0;
    int short_seen = 0;
    logic [15:0] raws [0:8] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h1234,
                                16'hC3A5, 16'h0F0F, 16'h8001, 16'h7FFE};
    always #5 sys_clk_in = ~sys_clk_in;
    // a released line shows the inverse of its last driven level
    assign line_a = oe_a ? ~last_a : out_a;
    assign line_b = oe_b ? ~last_b : out_b;
    always @(posedge sys_clk_in) begin
        if (oe_a === 1'b0) last_a <= out_a;
        if (oe_b === 1'b0) last_b <= out_b;
        if (abort_p === 1'b1) abort_seen <= abort_seen + 1;
        if (short_p === 1'b1) short_seen <= short_seen + 1;
    end
    dasr_top #(.RES_BITS(RES), .FIFO_DEPTH(FIFO_DEPTH_DEF)) u_dasr_top (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .frame_sel_n_in(sel_n),
        .serial_clk_in(sclk), .sample_in(sample_in), .sample_valid_in(sample_valid_in),
        .sample_ready_out(sample_ready_out), .channel_a_serial_out(out_a),
        .channel_a_serial_oe_n_out(oe_a), .channel_b_serial_out(out_b),
        .channel_b_serial_oe_n_out(oe_b), .sample_hold_out(hold),
        .frame_active_out(active), .conversion_abort_out(abort_p),
        .acquisition_short_out(short_p));
    dasr_host_model u_dasr_host_model (.sys_clk_in(sys_clk_in), .line_a_in(line_a),
        .line_b_in(line_b), .frame_sel_n_out(sel_n), .serial_clk_out(sclk));
    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // twos complement code of a raw offset binary sample, laid out per falling edge
    function automatic logic [32:1] exp_bits(input logic [15:0] raw, input int falls);
        logic [15:0] code;
        code = raw ^ 16'h8000;
        exp_bits = '0;
        for (int k = MSB_EDGE; k <= CONV_EDGES + RES && k <= falls; k++) begin
            exp_bits[k] = code[CONV_EDGES + RES - k];
        end
    endfunction
    task automatic push(input logic [15:0] ra);
        @(negedge sys_clk_in);
        sample_in = '{chan_a: ra, chan_b: ra ^ 16'h5A5A};
        sample_valid_in = 1'b1;
        for (int t = 0; t < 50 && sample_ready_out !== 1'b1; t++) @(negedge sys_clk_in);
        @(negedge sys_clk_in);
        sample_valid_in = 1'b0;
    endtask
    task automatic frame(input int falls, input int high_cyc, input logic [15:0] ra);
        logic [32:1] ba, bb;
        u_dasr_host_model.do_frame(falls, high_cyc, ba, bb);
        check("channel a bits", exp_bits(ra, falls), ba);
        check("channel b bits", exp_bits(ra ^ 16'h5A5A, falls), bb);
    endtask
    task automatic t_fill();
        for (int i = 0; i < 9; i++) push(raws[i]);
        @(negedge sys_clk_in);
        sample_valid_in = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        check("ready when full", 32'h0, {31'h0, sample_ready_out});
        sample_valid_in = 1'b0;
    endtask
    task automatic t_full();
        for (int i = 0; i < 4; i++) frame(32, 20, raws[i]);
        check("no abort on full frames", 32'h0, abort_seen);
    endtask
    task automatic t_abort();
        frame(10, 3, 16'h8000);
        // abort pulse lands about five clocks after the select pin rises;
        // the wait still keeps the high time well under the abort minimum
        repeat (4) @(negedge sys_clk_in);
        check("early abort flagged", 32'h1, abort_seen);
        check("hold released", 32'h0, {31'h0, hold});
        frame(20, 20, raws[5]);
        check("short high time flagged", 32'h1, short_seen);
        frame(32, 20, raws[6]);
        check("full high time accepted", 32'h1, short_seen);
    endtask
    task automatic t_drain();
        logic [32:1] ba, bb;
        frame(32, 20, raws[7]);
        frame(32, 20, raws[8]);
        // fifo now empty: both channels report the midscale code
        u_dasr_host_model.do_frame(32, 20, ba, bb);
        check("empty channel a bits", exp_bits(16'h8000, 32), ba);
        check("empty channel b bits", exp_bits(16'h8000, 32), bb);
        check("ready after drain", 32'h1, {31'h0, sample_ready_out});
    endtask
    initial begin
        repeat (12) @(negedge sys_clk_in);
        rst_in = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        t_fill();
        t_full();
        t_abort();
        t_drain();
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge sys_clk_in);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
